/* hdl/rcl_pkg.sv */
// Package for the remote critical limit and filter control block.
// Assumes a single 200 MHz clock domain and a plain byte-wide register port.
package rcl_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_CRIT_LIMIT  = 8'h19;
  localparam logic [7:0] ADDR_CRIT_HYST   = 8'h21;
  localparam logic [7:0] ADDR_FILT_ALARM  = 8'hbf;

  // Power-on values
  localparam logic [7:0] RST_CRIT_LIMIT   = 8'h6e;  // 110 degrees
  localparam logic [7:0] RST_CRIT_HYST    = 8'h0a;  // 10 degrees
  localparam logic [7:0] RST_FILT_ALARM   = 8'h00;
  localparam logic [7:0] RD_UNMAPPED      = 8'h00;

  // Field positions in the filter and alarm mode register
  localparam int FA_CMP_BIT   = 0;
  localparam int FA_FILT_LO   = 1;
  localparam int FA_FILT_HI   = 2;
  localparam int FA_ZERO_LO   = 3;
  localparam int FA_ZERO_HI   = 5;
  localparam int FA_SPARE_LO  = 6;
  localparam int FA_SPARE_HI  = 7;
  localparam int HYST_W       = 7;

  // Temperature sample: 8 integer bits plus 3 fraction bits (1/8 degree)
  localparam int TEMP_W       = 11;
  localparam int FRAC_W       = 3;
  localparam int CMP_W        = TEMP_W + 2;

  // Decoded filter level
  typedef enum logic [1:0] {
    RCL_LVL_OFF = 2'b00,
    RCL_LVL_MIN = 2'b01,
    RCL_LVL_MAX = 2'b10
  } rcl_flevel_t;

  // Register write request
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } rcl_wr_t;

  // One finished remote conversion, both unfiltered and filtered
  typedef struct packed {
    logic [TEMP_W-1:0] raw;
    logic [TEMP_W-1:0] filt;
  } rcl_sample_t;

endpackage

/* hdl/rcl_crit_cmp.sv */
// Critical limit comparator with hysteresis threshold.
// Assumes the temperature and limit share the format chosen by usf_i.
`timescale 1ns/100ps
module rcl_crit_cmp (
  input  wire logic [rcl_pkg::TEMP_W-1:0] temp_i,
  input  wire logic                       usf_i,
  input  wire logic [7:0]                 limit_i,
  input  wire logic [rcl_pkg::HYST_W-1:0] hyst_i,
  output logic                            above_o,
  output logic                            below_rel_o
);

  logic signed [rcl_pkg::CMP_W-1:0] temp_x;
  logic signed [rcl_pkg::CMP_W-1:0] lim_x;
  logic signed [rcl_pkg::CMP_W-1:0] rel_x;
  logic        [rcl_pkg::CMP_W-1:0] hyst_x;

  // Extend both operands to eighths of a degree; sign only when signed format
  always_comb begin
    if (usf_i) begin
      temp_x = {2'b00, temp_i};
      lim_x  = {2'b00, limit_i, 3'h0};
    end else begin
      temp_x = {{2{temp_i[rcl_pkg::TEMP_W-1]}}, temp_i};
      lim_x  = {{2{limit_i[7]}}, limit_i, 3'h0};
    end
    hyst_x = {3'h0, hyst_i, 3'h0};
    rel_x  = lim_x - $signed(hyst_x);
  end

  // Fractional part counts, so 110.125 is above a 110 limit
  assign above_o     = temp_x > lim_x;
  assign below_rel_o = temp_x < rel_x;

endmodule

/* hdl/rcl_ctrl.sv */
// Remote critical limit, hysteresis, filter select and alarm mode control.
// Assumes the conversion engine pulses conv_done_i with a settled sample and
// that the configuration register (override and format bits) lives outside.
`timescale 1ns/100ps

module rcl_ctrl (
  input  wire logic                  clk_i,
  input  wire logic                  resetn_i,
  input  wire logic                  wr_en_i,
  input  wire rcl_pkg::rcl_wr_t      wr_i,
  input  wire logic                  rd_en_i,
  input  wire logic [7:0]            rd_addr_i,
  output logic [7:0]                 rd_data_o,
  input  wire logic                  limit_override_i,
  input  wire logic                  unsigned_format_select_i,
  input  wire logic                  conv_done_i,
  input  wire rcl_pkg::rcl_sample_t  sample_i,
  input  wire logic                  flag_ack_i,
  output rcl_pkg::rcl_flevel_t       filter_level_o,
  output logic                       remote_crit_flag_o,
  output logic                       critical_output_o,
  output logic                       alarm_o
);

  logic [7:0]                 crit_limit_bits_q;
  logic [7:0]                 crit_hyst_q;
  logic [7:0]                 filt_alarm_q;
  logic [7:0]                 rd_data_q;
  logic                       crit_q;
  logic                       flag_q;
  logic [1:0]                 remote_filter_select;
  logic                       alarm_comparator_select;
  logic [rcl_pkg::TEMP_W-1:0] temp_sel;
  logic                       above;
  logic                       below_rel;
  logic                       wr_limit;
  logic                       wr_hyst;
  logic                       wr_filt;

  // Filter select decode; 01 and 10 share one level
  function automatic rcl_pkg::rcl_flevel_t dec_filter(input logic [1:0] sel);
    case (sel)
      2'b00:   dec_filter = rcl_pkg::RCL_LVL_OFF;
      2'b01:   dec_filter = rcl_pkg::RCL_LVL_MIN;
      2'b10:   dec_filter = rcl_pkg::RCL_LVL_MIN;
      default: dec_filter = rcl_pkg::RCL_LVL_MAX;
    endcase
  endfunction

  // Write decodes
  assign wr_limit = wr_en_i && (wr_i.addr == rcl_pkg::ADDR_CRIT_LIMIT);
  assign wr_hyst  = wr_en_i && (wr_i.addr == rcl_pkg::ADDR_CRIT_HYST);
  assign wr_filt  = wr_en_i && (wr_i.addr == rcl_pkg::ADDR_FILT_ALARM);

  assign remote_filter_select    = filt_alarm_q[rcl_pkg::FA_FILT_HI:rcl_pkg::FA_FILT_LO];
  assign alarm_comparator_select = filt_alarm_q[rcl_pkg::FA_CMP_BIT];

  // Critical limit; a set override freezes it against writes
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      crit_limit_bits_q <= rcl_pkg::RST_CRIT_LIMIT;
    end else if (wr_limit && !limit_override_i) begin
      crit_limit_bits_q <= wr_i.data;
    end
  end

  // Hysteresis; bit 7 stored only so software reads back what it wrote
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      crit_hyst_q <= rcl_pkg::RST_CRIT_HYST;
    end else if (wr_hyst) begin
      crit_hyst_q <= wr_i.data;
    end
  end

  // Filter and alarm mode; bits 5:3 are never stored
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      filt_alarm_q <= rcl_pkg::RST_FILT_ALARM;
    end else if (wr_filt) begin
      // Spare bits 7:6 are kept as written; software is expected to write zero
      filt_alarm_q <= {wr_i.data[rcl_pkg::FA_SPARE_HI:rcl_pkg::FA_SPARE_LO],
                       3'h0,
                       wr_i.data[rcl_pkg::FA_FILT_HI:rcl_pkg::FA_CMP_BIT]};
    end
  end

  // Registered read data, one cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      rd_data_q <= rcl_pkg::RD_UNMAPPED;
    end else if (rd_en_i) begin
      case (rd_addr_i)
        rcl_pkg::ADDR_CRIT_LIMIT: rd_data_q <= crit_limit_bits_q;
        rcl_pkg::ADDR_CRIT_HYST:  rd_data_q <= crit_hyst_q;
        rcl_pkg::ADDR_FILT_ALARM: rd_data_q <= filt_alarm_q;
        default:                  rd_data_q <= rcl_pkg::RD_UNMAPPED;
      endcase
    end
  end

  assign rd_data_o      = rd_data_q;
  assign filter_level_o = dec_filter(remote_filter_select);

  // Compare the filtered result unless filtering is off
  assign temp_sel = (dec_filter(remote_filter_select) == rcl_pkg::RCL_LVL_OFF) ?
                    sample_i.raw : sample_i.filt;

  // Only the low seven hysteresis bits reach the comparator
  rcl_crit_cmp u_cmp (
    .temp_i      (temp_sel),
    .usf_i       (unsigned_format_select_i),
    .limit_i     (crit_limit_bits_q),
    .hyst_i      (crit_hyst_q[rcl_pkg::HYST_W-1:0]),
    .above_o     (above),
    .below_rel_o (below_rel)
  );

  // Critical output: set above limit, released only below the hysteresis point
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      crit_q <= 1'b0;
    end else if (conv_done_i) begin
      if (above) begin
        crit_q <= 1'b1;
      end else if (below_rel) begin
        crit_q <= 1'b0;
      end
    end
  end

  // Sticky flag; a conversion above the limit beats a same-cycle acknowledge
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      flag_q <= 1'b0;
    end else if (conv_done_i && above) begin
      flag_q <= 1'b1;
    end else if (flag_ack_i && !crit_q) begin
      flag_q <= 1'b0;
    end
  end

  assign remote_crit_flag_o = flag_q;
  assign critical_output_o  = crit_q;
  // Comparator mode tracks the live condition instead of the latched flag
  assign alarm_o = alarm_comparator_select ? crit_q : flag_q;

  AST_LIMIT_RESET: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $rose(resetn_i) |-> crit_limit_bits_q == rcl_pkg::RST_CRIT_LIMIT)
    else $error("Critical limit not at its reset value");

  AST_LIMIT_LOCK: assert property (@(posedge clk_i) disable iff (!resetn_i)
    wr_limit && limit_override_i |=> $stable(crit_limit_bits_q))
    else $error("Locked critical limit changed");

  AST_LIMIT_WRITE: assert property (@(posedge clk_i) disable iff (!resetn_i)
    wr_limit && !limit_override_i |=> crit_limit_bits_q == $past(wr_i.data))
    else $error("Unlocked critical limit write lost");

  AST_HYST_WRITE: assert property (@(posedge clk_i) disable iff (!resetn_i)
    wr_hyst |=> crit_hyst_q[6:0] == $past(wr_i.data[6:0]))
    else $error("Hysteresis write lost");

  AST_CRIT_SET: assert property (@(posedge clk_i) disable iff (!resetn_i)
    conv_done_i && above |=> critical_output_o && remote_crit_flag_o)
    else $error("Critical event did not set output and flag");

  AST_CRIT_HOLD: assert property (@(posedge clk_i) disable iff (!resetn_i)
    critical_output_o && !(conv_done_i && below_rel) |=> critical_output_o)
    else $error("Critical output dropped above release point");

  AST_CRIT_RELEASE: assert property (@(posedge clk_i) disable iff (!resetn_i)
    conv_done_i && below_rel && !above |=> !critical_output_o)
    else $error("Critical output not released");

  AST_RD_ZERO: assert property (@(posedge clk_i) disable iff (!resetn_i)
    rd_en_i && rd_addr_i == rcl_pkg::ADDR_FILT_ALARM |=> rd_data_o[5:3] == 3'h0)
    else $error("Reserved filter bits read nonzero");

  AST_FILT_MAX: assert property (@(posedge clk_i) disable iff (!resetn_i)
    remote_filter_select == 2'b11 |-> filter_level_o == rcl_pkg::RCL_LVL_MAX)
    else $error("Filter select 11 not decoded as maximum");

  AST_CMP_MODE: assert property (@(posedge clk_i) disable iff (!resetn_i)
    alarm_comparator_select && !critical_output_o && $past(critical_output_o)
    |-> !alarm_o)
    else $error("Comparator-mode alarm did not release");

  // The flag is sticky: only an acknowledge may take it down
  AST_FLAG_STICKY: assert property (@(posedge clk_i) disable iff (!resetn_i)
    remote_crit_flag_o && !flag_ack_i |=> remote_crit_flag_o)
    else $error("Critical flag cleared without acknowledge");

  // An acknowledge while the critical output is active must not lose the event
  AST_FLAG_KEEP: assert property (@(posedge clk_i) disable iff (!resetn_i)
    remote_crit_flag_o && critical_output_o |=> remote_crit_flag_o)
    else $error("Critical flag cleared while critical output active");

  AST_FILT_MIN: assert property (@(posedge clk_i) disable iff (!resetn_i)
    ^remote_filter_select |-> filter_level_o == rcl_pkg::RCL_LVL_MIN)
    else $error("Filter select 01 or 10 not decoded as minimal");

  AST_FILT_OFF: assert property (@(posedge clk_i) disable iff (!resetn_i)
    remote_filter_select == 2'b00 |-> filter_level_o == rcl_pkg::RCL_LVL_OFF)
    else $error("Filter select 00 not decoded as off");

  // Between conversions the critical output must not move
  AST_CRIT_IDLE: assert property (@(posedge clk_i) disable iff (!resetn_i)
    !conv_done_i |=> $stable(critical_output_o))
    else $error("Critical output changed without a conversion");

  AST_RESET_OUTS: assert property (@(posedge clk_i) disable iff (!resetn_i)
    $rose(resetn_i) |-> crit_hyst_q == rcl_pkg::RST_CRIT_HYST
    && !critical_output_o && !remote_crit_flag_o)
    else $error("Hysteresis or outputs not at reset values");

endmodule

/* test/rcl_diode_model.sv */
// Stand-in for the remote diode and conversion engine feeding the limit block.
// Assumes the bench raises start_i for one cycle per finished conversion.
`timescale 1ns/100ps
module rcl_diode_model (
  input  wire logic                       clk_i,
  input  wire logic                       start_i,
  input  wire logic [rcl_pkg::TEMP_W-1:0] raw_i,
  input  wire logic [rcl_pkg::TEMP_W-1:0] filt_i,
  output logic                            conv_done_o,
  output rcl_pkg::rcl_sample_t            sample_o
);
  // One done pulse per request; the sample is inverted each cycle between conversions
  // so a stale value reads back unchanged only on every second cycle
  always_ff @(posedge clk_i) begin
    conv_done_o <= start_i;
    if (start_i) begin
      sample_o <= '{raw: raw_i, filt: filt_i};
    end else begin
      sample_o <= ~sample_o;
    end
  end
endmodule

/* test/rcl_ctrl_bench.sv */
// Self-checking bench for the critical limit, hysteresis and filter control.
// Assumes the byte register port and one-cycle conversion pulses of rcl_ctrl.
`timescale 1ns/100ps
module rcl_ctrl_bench;
  logic                 clk_i = 1'b0;
  logic                 resetn_i = 1'b0;
  logic                 wr_en_i = 1'b0;
  logic                 rd_en_i = 1'b0;
  logic                 flag_ack_i = 1'b0;
  logic                 limit_override_i = 1'b1;
  logic                 unsigned_format_select_i = 1'b0;
  logic                 start = 1'b0;
  logic [10:0]          raw = 11'h000;
  logic [10:0]          filt = 11'h000;
  logic [7:0]           rd_addr_i = 8'h00;
  logic [7:0]           rd_data_o;
  logic                 conv_done_i;
  logic                 remote_crit_flag_o;
  logic                 critical_output_o;
  logic                 alarm_o;
  rcl_pkg::rcl_wr_t     wr_i = '0;
  rcl_pkg::rcl_sample_t sample_i;
  rcl_pkg::rcl_flevel_t filter_level_o;
  rcl_pkg::rcl_flevel_t lv [4] = '{rcl_pkg::RCL_LVL_OFF, rcl_pkg::RCL_LVL_MIN,
                                   rcl_pkg::RCL_LVL_MIN, rcl_pkg::RCL_LVL_MAX};
  int                   err_total = 0;
  int                   n_checks = 0;

  rcl_ctrl dut_u (.clk_i(clk_i), .resetn_i(resetn_i), .wr_en_i(wr_en_i), .wr_i(wr_i),
    .rd_en_i(rd_en_i), .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o),
    .limit_override_i(limit_override_i), .unsigned_format_select_i(unsigned_format_select_i),
    .conv_done_i(conv_done_i), .sample_i(sample_i), .flag_ack_i(flag_ack_i),
    .filter_level_o(filter_level_o), .remote_crit_flag_o(remote_crit_flag_o),
    .critical_output_o(critical_output_o), .alarm_o(alarm_o));
  rcl_diode_model diode_u (.clk_i(clk_i), .start_i(start), .raw_i(raw), .filt_i(filt),
    .conv_done_o(conv_done_i), .sample_o(sample_i));

  // 200 MHz clock
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_en_i <= 1'b1;
    wr_i    <= '{addr: a, data: d};
    @(posedge clk_i);
    wr_en_i <= 1'b0;
  endtask

  // Read data lands on the edge after the strobe; sampled once settled
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    rd_en_i   <= 1'b1;
    rd_addr_i <= a;
    @(posedge clk_i);
    rd_en_i <= 1'b0;
    #1;
    chk("register read", exp, rd_data_o);
  endtask

  task automatic outs(input logic c, input logic fl, input logic al);
    chk("critical output", {7'h00, c}, {7'h00, critical_output_o});
    chk("critical flag", {7'h00, fl}, {7'h00, remote_crit_flag_o});
    chk("alarm", {7'h00, al}, {7'h00, alarm_o});
  endtask

  // Model pulses done one edge after start; design answers one edge later
  task automatic conv(input logic [10:0] r, input logic [10:0] f,
                      input logic c, input logic fl, input logic al);
    @(posedge clk_i);
    start <= 1'b1;
    raw   <= r;
    filt  <= f;
    @(posedge clk_i);
    start <= 1'b0;
    @(posedge clk_i);
    #1;
    outs(c, fl, al);
  endtask

  task automatic ack(input logic al);
    @(posedge clk_i);
    flag_ack_i <= 1'b1;
    @(posedge clk_i);
    flag_ack_i <= 1'b0;
    #1;
    outs(1'b0, 1'b0, al);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Watchdog: the sequence needs well under 1000 cycles
  initial begin
    #20000;
    err_total++;
    tally_and_finish;
  end

  initial begin
    repeat (2) @(posedge clk_i);
    resetn_i <= 1'b1;
    rd(rcl_pkg::ADDR_CRIT_LIMIT, 8'h6e);
    rd(rcl_pkg::ADDR_CRIT_HYST, 8'h0a);
    rd(rcl_pkg::ADDR_FILT_ALARM, 8'h00);
    rd(8'h55, 8'h00);
    wr(rcl_pkg::ADDR_CRIT_LIMIT, 8'h50);
    rd(rcl_pkg::ADDR_CRIT_LIMIT, 8'h6e);
    @(posedge clk_i) limit_override_i <= 1'b0;
    wr(rcl_pkg::ADDR_CRIT_LIMIT, 8'h50);
    rd(rcl_pkg::ADDR_CRIT_LIMIT, 8'h50);
    wr(rcl_pkg::ADDR_FILT_ALARM, 8'h3f);
    rd(rcl_pkg::ADDR_FILT_ALARM, 8'h07);
    // Every filter select code, comparator mode off
    for (int s = 0; s < 4; s++) begin
      wr(rcl_pkg::ADDR_FILT_ALARM, {5'h00, s[1:0], 1'b0});
      @(negedge clk_i) chk("filter level", {6'h00, lv[s]}, {6'h00, filter_level_o});
    end
    wr(rcl_pkg::ADDR_CRIT_HYST, 8'h8a);
    rd(rcl_pkg::ADDR_CRIT_HYST, 8'h8a);
    wr(rcl_pkg::ADDR_CRIT_LIMIT, 8'h6e);
    wr(rcl_pkg::ADDR_FILT_ALARM, 8'h00);
    // Limit 110, hysteresis 10: above beyond 880, release below 800
    conv(11'd880, 11'd2000, 1'b0, 1'b0, 1'b0);
    conv(11'd881, 11'd0, 1'b1, 1'b1, 1'b1);
    conv(11'd800, 11'd0, 1'b1, 1'b1, 1'b1);
    conv(11'd799, 11'd2000, 1'b0, 1'b1, 1'b1);
    ack(1'b0);
    wr(rcl_pkg::ADDR_FILT_ALARM, 8'h07);
    conv(11'd0, 11'd881, 1'b1, 1'b1, 1'b1);
    conv(11'd2000, 11'd799, 1'b0, 1'b1, 1'b0);
    ack(1'b0);
    // Limit 0xfb: 251 unsigned, -5 signed; sample 32 degrees
    wr(rcl_pkg::ADDR_FILT_ALARM, 8'h00);
    wr(rcl_pkg::ADDR_CRIT_LIMIT, 8'hfb);
    @(posedge clk_i) unsigned_format_select_i <= 1'b1;
    conv(11'h100, 11'h000, 1'b0, 1'b0, 1'b0);
    @(posedge clk_i) unsigned_format_select_i <= 1'b0;
    conv(11'h100, 11'h000, 1'b1, 1'b1, 1'b1);
    // Acknowledge while still critical must leave the flag set
    @(posedge clk_i) flag_ack_i <= 1'b1;
    @(posedge clk_i) flag_ack_i <= 1'b0;
    #1;
    outs(1'b1, 1'b1, 1'b1);
    tally_and_finish;
  end
endmodule
